// ==== cjlu_pkg.sv ====
package cjlu_pkg;
  localparam logic [4:0]  MAJ_REGION    = 5'h03;  // region call major code
  localparam logic [4:0]  MAJ_REGREG    = 5'h1d;  // regreg_major
  localparam logic [4:0]  FN_JUMPREG    = 5'h00;  // jump-through-register
  localparam logic [5:0]  OP32_SWAP     = 6'h1d;  // 32-bit swap call opcode
  localparam int          POS_SWAP      = 26;
  localparam int          POS_NOSLOT    = 7;
  localparam int          POS_LINK      = 6;
  localparam int          POS_RETREG    = 5;
  localparam logic [31:0] LINK_REGION   = 32'h0000_0006;
  localparam logic [31:0] LINK_DELAYED  = 32'h0000_0004;
  localparam logic [31:0] LINK_COMPACT  = 32'h0000_0002;
  localparam logic [31:0] SLOT_STEP     = 32'h0000_0004;
  localparam logic [4:0]  RETREG_IDX    = 5'h1f;
  localparam logic [31:0] RESET_PC      = 32'h0000_0000;
  localparam logic        RESET_MODE    = 1'b0;
  typedef enum logic [1:0] {CJLU_IDLE, CJLU_SLOT} cjlu_state_e;
endpackage

// ==== cjlu_unit.sv ====
`timescale 1ns/1ps
// Contract
// - region call is major 00011 in 31:27, bit 26 picks keep or swap, target fields are swizzled.
// - compact region calls link pc plus 6 with the current mode in bit 0.
// - region target low 28 bits are the 26-bit field shifted left by two.
// - target bits above 27 come from the delay-slot address.
// - the keeping region call leaves the mode bit unchanged.
// - the compact swapping region call inverts the mode bit.
// - region calls run one delay-slot instruction before redirecting.
// - register jumps are major 11101, function 00000, flags in bits 7..5.
// - register call targets have bit 0 forced to zero, with no error.
// - the delayed register call redirects after a slot, mode from src bit 0.
// - the delayed register call links pc plus 4 with the current mode.
// - the compact register call redirects and sets mode at once.
// - the compact register call links pc plus 2 with the current mode.
// - a register target with bit 0 clear and bit 1 set raises address error.
// - the 32-bit swap call inverts the mode and takes its target from its plain index field.
module cjlu_unit (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr,
  input  wire logic [31:0] instr_pc,
  input  wire logic [31:0] src_data,
  output logic [4:0]       src_idx,
  output logic             link_we,
  output logic [4:0]       link_idx,
  output logic [31:0]      link_data,
  output logic             redirect,
  output logic [31:0]      redirect_pc,
  output logic             instr_set_sel,
  output logic             addr_err,
  output logic             slot_busy
);
  cjlu_pkg::cjlu_state_e state;
  cjlu_pkg::cjlu_state_e next_state;
  logic [31:0] pend_pc;
  logic        pend_mode;
  logic        pend_err;

  // the unit sees one instruction step per valid cycle. the fetch side
  // offers the delay-slot step like any other step, and the unit only
  // counts it. a call placed in the slot is never decoded: running it
  // would need a second parked target, and such code is not legal anyway.
  // the source register value arrives in the same cycle through src_idx,
  // so the register file read path is part of this step's timing.
  // src_idx is therefore the one output that is not a flop.

  // field extraction and decode; compact halfword sits in instr[15:0]
  wire logic [4:0]  maj32     = instr[31:27];
  wire logic [4:0]  maj16     = instr[15:11];
  wire logic [2:0]  src_field = instr[10:8];
  wire logic        no_slot_flag = instr[cjlu_pkg::POS_NOSLOT];
  wire logic        link_flag    = instr[cjlu_pkg::POS_LINK];
  wire logic        src_is_retreg = instr[cjlu_pkg::POS_RETREG];
  // region call decode
  // only in compact mode; in 32-bit mode this major code means other
  // instructions, so decoding it there would steal their encodings
  wire logic        is_region = instr_set_sel
                    && maj32 == cjlu_pkg::MAJ_REGION;
  wire logic        call_region_keep = is_region
                    && !instr[cjlu_pkg::POS_SWAP];
  wire logic        call_region_swap = is_region
                    && instr[cjlu_pkg::POS_SWAP];
  // 32-bit format swap call, only decoded in 32-bit mode
  // the opcode value is a local choice kept in the package constant
  wire logic        call_swap_32 = !instr_set_sel
                    && instr[31:26] == cjlu_pkg::OP32_SWAP;
  // register jump decode with flag values
  // masked when the upper half holds a region call, whose low target
  // bits may look like a register jump halfword
  wire logic        is_regjump = instr_set_sel
                    && maj32 != cjlu_pkg::MAJ_REGION
                    && maj16 == cjlu_pkg::MAJ_REGREG
                    && instr[4:0] == cjlu_pkg::FN_JUMPREG
                    && link_flag && !src_is_retreg;
  wire logic        call_reg_delayed = is_regjump && !no_slot_flag;
  wire logic        call_reg_compact = is_regjump && no_slot_flag;
  wire logic        go = instr_valid && state == cjlu_pkg::CJLU_IDLE;

  wire logic [25:0] tgt16 = {instr[20:16], instr[25:21], instr[15:0]};
  wire logic [25:0] tgt_field = call_swap_32 ? instr[25:0] : tgt16;
  // upper bits follow the slot instruction address
  // a call in the last word of a region thus lands in the next region;
  // using the call's own address here would wrap back instead
  wire logic [31:0] slot_pc = instr_pc + cjlu_pkg::SLOT_STEP;
  // low 28 bits are the word index shifted by two
  wire logic [31:0] region_tgt = {slot_pc[31:28], tgt_field, 2'b00};
  // bit 0 is the mode, never an alignment fault
  wire logic [31:0] reg_tgt = {src_data[31:1], 1'b0};
  // halfword-only misalignment in 32-bit mode target
  // the fault rides with the redirect, so the core can drop the fetch
  // at the bad target instead of tracking it down the pipe
  wire logic        reg_misal = !src_data[0] && src_data[1];

  // link offsets; for the register forms
  // the 32-bit swap call shares the region offset; no other value is
  // defined for it, and it keeps the return point past the slot
  wire logic [31:0] link_off = call_reg_compact ? cjlu_pkg::LINK_COMPACT
                    : call_reg_delayed ? cjlu_pkg::LINK_DELAYED
                    : cjlu_pkg::LINK_REGION;
  wire logic [31:0] link_sum = instr_pc + link_off;
  wire logic        any_call = call_region_keep || call_region_swap
                    || call_swap_32 || is_regjump;
  wire logic        needs_slot = call_region_keep || call_region_swap
                    || call_swap_32 || call_reg_delayed;

  // one-cycle events that the flops act on; naming them keeps the
  // clocked blocks down to plain loads
  // a slot call parks its target until the slot step is seen
  wire logic        take_slot = go && needs_slot;
  // the compact register call acts in its own step
  wire logic        take_now  = go && call_reg_compact;
  wire logic        slot_done = instr_valid
                    && state == cjlu_pkg::CJLU_SLOT;
  wire logic        tgt_mode  = call_region_keep ? instr_set_sel
                    : is_regjump ? src_data[0] : !instr_set_sel;
  // only register targets can be misaligned
  wire logic        tgt_err   = is_regjump && reg_misal;
  // parked target: register value or region target
  wire logic [31:0] tgt_pc    = is_regjump ? reg_tgt : region_tgt;

  // compact register translation, 0,1 map to 16,17
  // the short field reaches eight registers; the two low codes point
  // at the first argument registers instead of the zero register
  assign src_idx = src_field[2:1] == 2'b00 ? {2'b10, src_field}
                                           : {2'b00, src_field};

  // sequencing: slot state holds the pending redirect for one step
  // a cycle without instr_valid just waits, so fetch may stall between
  // the call and its slot without losing the parked target
  always_comb begin
    next_state = state;
    case (state)
      cjlu_pkg::CJLU_IDLE: begin
        // slot first, redirect on the following step
        if (take_slot) begin
          next_state = cjlu_pkg::CJLU_SLOT;
        end
      end
      cjlu_pkg::CJLU_SLOT: begin
        if (instr_valid) begin
          next_state = cjlu_pkg::CJLU_IDLE;
        end
      end
      default: next_state = cjlu_pkg::CJLU_IDLE;
    endcase
  end

  // pending target, mode and error captured at the call
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state     <= cjlu_pkg::CJLU_IDLE;
      pend_pc   <= cjlu_pkg::RESET_PC;
      pend_mode <= cjlu_pkg::RESET_MODE;
      pend_err  <= 1'b0;
    end else begin
      state <= next_state;
      if (take_slot) begin
        pend_pc   <= tgt_pc;
        // mode worked out at the call step: src bit 0 for register calls, kept or inverted for the others
        pend_mode <= tgt_mode;
        pend_err  <= tgt_err;
      end
    end
  end

  // link write, one cycle pulse in the call step
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      link_we   <= 1'b0;
      link_idx  <= cjlu_pkg::RETREG_IDX;
      link_data <= cjlu_pkg::RESET_PC;
    end else begin
      link_we   <= go && any_call;
      link_idx  <= cjlu_pkg::RETREG_IDX;
      // drop bit 0 of the sum, carry the current mode
      link_data <= {link_sum[31:1], instr_set_sel};
    end
  end

  // redirect, mode and fault; compact call acts at once
  // a reset while a slot is pending drops the parked target; the fetch
  // side restarts from its own reset address, so nothing is lost
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      redirect      <= 1'b0;
      redirect_pc   <= cjlu_pkg::RESET_PC;
      instr_set_sel <= cjlu_pkg::RESET_MODE;
      addr_err      <= 1'b0;
      slot_busy     <= 1'b0;
    end else begin
      redirect  <= 1'b0;
      addr_err  <= 1'b0;
      slot_busy <= next_state == cjlu_pkg::CJLU_SLOT;
      if (take_now) begin
        // same step redirect and mode; error at fetch
        redirect      <= 1'b1;
        redirect_pc   <= reg_tgt;
        instr_set_sel <= src_data[0];
        addr_err      <= reg_misal;
      end else if (slot_done) begin
        // slot done, now take the target; mode update
        redirect      <= 1'b1;
        redirect_pc   <= pend_pc;
        instr_set_sel <= pend_mode;
        // fault flagged with the target fetch
        addr_err      <= pend_err;
      end
    end
  end
endmodule

// ==== cjlu_unit_assertions.sv ====
`timescale 1ns/1ps
module cjlu_chk (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        instr_valid,
  input wire logic [31:0] instr,
  input wire logic [31:0] src_data,
  input wire logic [4:0]  src_idx,
  input wire logic        link_we,
  input wire logic [4:0]  link_idx,
  input wire logic        redirect,
  input wire logic [31:0] redirect_pc,
  input wire logic        instr_set_sel,
  input wire logic        addr_err,
  input wire logic        slot_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // accepted steps; only compact-mode calls are modelled here, not the 32-bit swap call
  wire go = instr_valid && !slot_busy && instr_set_sel;
  wire rr = instr[15:11] == cjlu_pkg::MAJ_REGREG && instr[4:0] == 5'h00;
  wire rc = go && rr && instr[7:5] == 3'h6 && instr[31:27] != 5'h03;
  wire rs = go && (instr[31:27] == 5'h03 || rr && instr[7:5] == 3'h2);
  // timing of each compact-mode call kind; values of the compact register call
  property p_rc; rc |=> link_we && redirect && link_idx == 5'h1f; endproperty
  a_rc: assert property (p_rc) else $error("call late");
  property p_b0; redirect |-> !redirect_pc[0]; endproperty
  a_b0: assert property (p_b0) else $error("odd target");
  property p_pc; rc |=> redirect_pc[31:1] == $past(src_data[31:1]); endproperty
  a_pc: assert property (p_pc) else $error("bad target");
  property p_er; rc && src_data[1:0] == 2'h2 |=> addr_err; endproperty
  a_er: assert property (p_er) else $error("no error");
  property p_ok; rc && src_data[0] |=> !addr_err && instr_set_sel; endproperty
  a_ok: assert property (p_ok) else $error("bad mode");
  property p_rs; rs |=> link_we && slot_busy && !redirect; endproperty
  a_rs: assert property (p_rs) else $error("no slot");
  property p_sl; slot_busy && instr_valid |=> redirect && !slot_busy; endproperty
  a_sl: assert property (p_sl) else $error("slot end");
  property p_xl; instr_set_sel && rr |-> src_idx ==
    (instr[10:9] == 2'h0 ? {4'h8, instr[8]} : {2'h0, instr[10:8]}); endproperty
  a_xl: assert property (p_xl) else $error("bad index");
  c_rc: cover property (rc);
  c_rs: cover property (rs);
  c_er: cover property (addr_err);
endmodule
bind cjlu_unit cjlu_chk i_cjlu_chk (.*);

// ==== cjlu_regs_model.sv ====
`timescale 1ns/1ps
module cjlu_regs_model (
  input  wire logic        clk_sys,
  input  wire logic [4:0]  src_idx,
  input  wire logic        link_we,
  input  wire logic [4:0]  link_idx,
  input  wire logic [31:0] link_data,
  output logic [31:0]      src_data
);
  logic [31:0] regs [32];
  // read is combinational: the unit wants the value in the same cycle
  assign src_data = regs[src_idx];
  // plain always so the bench may preload registers
  always @(posedge clk_sys) begin
    if (link_we) regs[link_idx] <= link_data;
  end
endmodule

// ==== test_compact_isa_jump_link_unit.sv ====
`timescale 1ns/1ps
module test_compact_isa_jump_link_unit;
  typedef struct packed {
    logic [31:0] ins, pc, src, lnk, tgt;
    logic        slot, mode, err;
  } cjlu_row_s;
  logic        clk_sys = 1'h0;
  logic        sys_rst = 1'h1;
  logic        instr_valid = 1'h0;
  logic [31:0] instr = '0;
  logic [31:0] instr_pc = '0;
  logic [31:0] src_data, link_data, redirect_pc;
  logic [4:0]  src_idx, link_idx;
  logic        link_we, redirect, instr_set_sel, addr_err, slot_busy;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  // call, pc, source, link, target, slot, mode after, error
  cjlu_row_s rows [11] = '{
    '{32'h74000040, 32'h100, 32'h0, 32'h106, 32'h100, 1'h1, 1'h1, 1'h0},
    '{32'heac0, 32'h200, 32'h1001, 32'h203, 32'h1000, 1'h0, 1'h1, 1'h0},
    '{32'he8c0, 32'h300, 32'h2003, 32'h303, 32'h2002, 1'h0, 1'h1, 1'h0},
    '{32'hea40, 32'h400, 32'h3001, 32'h405, 32'h3000, 1'h1, 1'h1, 1'h0},
    '{32'h18410010, 32'h500, 32'h0, 32'h507, 32'h880040, 1'h1, 1'h1, 1'h0},
    '{32'h18410010, 32'hffffffc, 32'h0, 32'h10000003, 32'h10880040,
      1'h1, 1'h1, 1'h0},
    '{32'h1c410010, 32'h700, 32'h0, 32'h707, 32'h880040, 1'h1, 1'h0, 1'h0},
    '{32'h74000040, 32'h800, 32'h0, 32'h806, 32'h100, 1'h1, 1'h1, 1'h0},
    '{32'heac0, 32'h900, 32'h4002, 32'h903, 32'h4002, 1'h0, 1'h0, 1'h1},
    '{32'h74000040, 32'ha00, 32'h0, 32'ha06, 32'h100, 1'h1, 1'h1, 1'h0},
    '{32'hea40, 32'hb00, 32'h5002, 32'hb05, 32'h5002, 1'h1, 1'h0, 1'h1}};
  cjlu_unit i_cjlu_unit (.*);
  cjlu_regs_model i_cjlu_regs_model (.*);
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one call, its slot if it has one, then the redirect
  task automatic run(cjlu_row_s r);
    i_cjlu_regs_model.regs[2] = r.src;
    i_cjlu_regs_model.regs[16] = r.src;
    instr_valid = 1'h1;
    instr = r.ins;
    instr_pc = r.pc;
    @(posedge clk_sys) #10;
    chk("link_we", 6'h3f, {link_we, link_idx});
    chk("link", r.lnk, link_data);
    if (r.slot) begin
      chk("slot", 2'h1, {redirect, slot_busy});
      instr = '0;
      instr_pc = r.pc + 32'h4;
      @(posedge clk_sys) #10;
    end
    chk("redir", 2'h2, {redirect, slot_busy});
    chk("target", r.tgt, redirect_pc);
    chk("mode", r.mode, instr_set_sel);
    chk("addr_err", r.err, addr_err);
  endtask
  initial forever #50 clk_sys = ~clk_sys;
  // hang guard, far above the 45 cycles needed
  always @(posedge clk_sys) begin
    if (++cyc == 1000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    #10 sys_rst = 1'h0;
    chk("reset", 10'h1f, {link_we, redirect, addr_err, slot_busy,
        instr_set_sel, link_idx});
    foreach (rows[i]) run(rows[i]);
    // 32-bit mode: a compact region call word is ignored
    instr = 32'h18410010;
    @(posedge clk_sys) #10;
    chk("refused", 2'h0, {link_we, slot_busy});
    // a call offered in the slot is run as the slot, not decoded
    instr = 32'h74000040;
    @(posedge clk_sys) #10;
    chk("slot call", 2'h3, {link_we, slot_busy});
    @(posedge clk_sys) #10;
    chk("slot kept", 3'h2, {link_we, redirect, slot_busy});
    chk("slot mode", 1'h1, instr_set_sel);
    // reset in mid-run with a target parked
    instr = 32'h1c410010;
    @(posedge clk_sys) #10;
    chk("pend", 1'h1, slot_busy);
    sys_rst = 1'h1;
    instr_valid = 1'h0;
    @(posedge clk_sys) #10;
    sys_rst = 1'h0;
    chk("rst mid", 3'h0, {slot_busy, redirect, instr_set_sel});
    @(posedge clk_sys) #10;
    chk("no stale", 2'h0, {redirect, link_we});
    summarize();
  end
endmodule
